// *** setpoint_dac_link.sv ***
// analog output channel loader: shift then convert
`timescale 1ns/1ps
`include "setpoint_defs.svh"
module setpoint_dac_link #(
  parameter int SHIFT_CYC = `SP_DAC_SHIFT_CYC,
  parameter int CONV_CYC = `SP_DAC_CONV_CYC
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic load_in,
  input wire logic [1:0] chan_in,
  input wire logic [15:0] code_in,
  output logic busy_out,
  output logic done_out,
  output logic [1:0] dac_chan_out,
  output logic [15:0] dac_code_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    setpoint_pkg::dac_state_t st;
    logic [11:0] cnt;
    logic [1:0] chan;
    logic [15:0] code;
    logic [1:0] pend_chan;
    logic [15:0] pend_code;
    logic pend;
    logic done;
  } dac_reg_t;
  dac_reg_t cur_ff;
  dac_reg_t nxt_ff;

  // sequencing; a load while busy is kept so the last value wins
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.done = 1'b0;
    if (load_in && cur_ff.st != setpoint_pkg::DAC_IDLE) begin
      nxt_ff.pend = 1'b1;
      nxt_ff.pend_chan = chan_in;
      nxt_ff.pend_code = code_in;
    end
    case (cur_ff.st)
      setpoint_pkg::DAC_IDLE: begin
        if (load_in) begin
          nxt_ff.st = setpoint_pkg::DAC_SHIFT;
          nxt_ff.cnt = 12'(SHIFT_CYC - 1);
          nxt_ff.chan = chan_in;
          nxt_ff.code = code_in;
        end
      end
      setpoint_pkg::DAC_SHIFT: begin
        if (cur_ff.cnt == 12'h000) begin
          nxt_ff.st = setpoint_pkg::DAC_CONV;
          nxt_ff.cnt = 12'(CONV_CYC - 1);
        end else begin
          nxt_ff.cnt = cur_ff.cnt - 12'h001;
        end
      end
      setpoint_pkg::DAC_CONV: begin
        if (cur_ff.cnt == 12'h000) begin
          // conversion finished: output now valid
          nxt_ff.done = 1'b1;
          if (cur_ff.pend || load_in) begin
            nxt_ff.st = setpoint_pkg::DAC_SHIFT;
            nxt_ff.cnt = 12'(SHIFT_CYC - 1);
            nxt_ff.chan = load_in ? chan_in : cur_ff.pend_chan;
            nxt_ff.code = load_in ? code_in : cur_ff.pend_code;
            nxt_ff.pend = 1'b0;
          end else begin
            nxt_ff.st = setpoint_pkg::DAC_IDLE;
          end
        end else begin
          nxt_ff.cnt = cur_ff.cnt - 12'h001;
        end
      end
      default: nxt_ff.st = setpoint_pkg::DAC_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign busy_out = (cur_ff.st != setpoint_pkg::DAC_IDLE);
  assign done_out = cur_ff.done;
  assign dac_chan_out = cur_ff.chan;
  assign dac_code_out = cur_ff.code;
endmodule

// *** setpoint_defs.svh ***
// constants for the setpoint detect and output update block
`ifndef SETPOINT_DEFS_SVH
`define SETPOINT_DEFS_SVH
// ----------------------------------------
// sizes
// ----------------------------------------
`define SP_COUNT 16
`define SP_IDX_W 4
`define SP_DATA_W 16
`define SP_PORT_W 8
`define SP_DAC_COUNT 4
`define SP_TIMER_COUNT 4
// ----------------------------------------
// timing
// ----------------------------------------
`define SP_CLK_MHZ 125
`define SP_DAC_SHIFT_NS 1000
`define SP_DAC_CONV_NS 2000
`define SP_DAC_SHIFT_CYC ((`SP_DAC_SHIFT_NS * `SP_CLK_MHZ + 999) / 1000)
`define SP_DAC_CONV_CYC ((`SP_DAC_CONV_NS * `SP_CLK_MHZ) / 1000)
// ----------------------------------------
// reset values
// ----------------------------------------
`define SP_RESULT_RST 16'h0000
`define SP_PORT_RST 8'h00
`endif

// *** setpoint_detect_output_update.sv ***
// setpoint detection and output update core
// ----------------------------------------
// Functional notes
// - sixteen results, index zero in lsb
// - status bit follows current comparison
// - inside window uses strict both limits
// - true/false mode applies two values
// - true-only writes only when met
// - true-only triggers on rising detect
// - hysteresis forces two-value updates outside the limits
// - hysteresis low holds until above high
// - no change between hysteresis limits
// - most recent true setpoint wins output
// - port update writes masked bits only
// - sixteen-bit code to one of four dacs
// - timer value loaded on update
// - port updates same cycle as evaluation
// - dac adds shift plus conversion time
// - streaming may delay dac by pacer period
// - counter compares one sixteen-bit half
// - one setpoint per channel, once per scan
// - six comparison kinds offered
// - high and low sixteen-bit limits
// ----------------------------------------
`timescale 1ns/1ps
`include "setpoint_defs.svh"
module setpoint_detect_output_update #(
  parameter int NUM_SP = `SP_COUNT,
  parameter int SHIFT_CYC = `SP_DAC_SHIFT_CYC,
  parameter int CONV_CYC = `SP_DAC_CONV_CYC
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  // acquisition control
  input wire logic arm_in,
  input wire logic sample_valid_in,
  input wire logic [3:0] sample_sp_in,
  input wire logic sample_en_in,
  input wire logic [15:0] sample_in,
  input wire logic sample_is_count_in,
  input wire logic count_high_half_in,
  input wire logic [31:0] count_in,
  input wire logic scan_end_in,
  // setpoint configuration write
  input wire logic cfg_we_in,
  input wire logic [3:0] cfg_sp_in,
  input wire logic [2:0] cfg_cmp_in,
  input wire logic cfg_upd_in,
  input wire logic [1:0] cfg_tgt_true_in,
  input wire logic [1:0] cfg_tgt_false_in,
  input wire logic [15:0] cfg_high_in,
  input wire logic [15:0] cfg_low_in,
  input wire logic [15:0] cfg_val_true_in,
  input wire logic [15:0] cfg_val_false_in,
  input wire logic [7:0] cfg_mask_true_in,
  input wire logic [7:0] cfg_mask_false_in,
  input wire logic [1:0] cfg_sel_true_in,
  input wire logic [1:0] cfg_sel_false_in,
  // results and outputs
  output logic [15:0] setpoint_result_word_out,
  output logic [7:0] setpoint_driven_output_port_out,
  output logic timer_load_out,
  output logic [1:0] timer_sel_out,
  output logic [15:0] timer_value_out,
  output logic dac_load_out,
  output logic dac_busy_out,
  output logic [1:0] dac_chan_out,
  output logic [15:0] dac_code_out
);
  // ----------------------------------------
  // configuration memory
  // ----------------------------------------
  setpoint_pkg::cmp_mode_t cmp_mem [NUM_SP];
  setpoint_pkg::upd_mode_t upd_mem [NUM_SP];
  setpoint_pkg::target_t tgt_t_mem [NUM_SP];
  setpoint_pkg::target_t tgt_f_mem [NUM_SP];
  logic [15:0] hi_mem [NUM_SP]; // high limit
  logic [15:0] lo_mem [NUM_SP]; // low limit
  logic [15:0] vt_mem [NUM_SP]; // true / high value
  logic [15:0] vf_mem [NUM_SP]; // false / low value
  logic [7:0] mt_mem [NUM_SP]; // port mask for true value
  logic [7:0] mf_mem [NUM_SP]; // port mask for false value
  logic [1:0] st_mem [NUM_SP]; // dac or timer select, true
  logic [1:0] sf_mem [NUM_SP]; // dac or timer select, false

  // config writes; no reset, loaded before arming
  always_ff @(posedge clock_in) begin
    if (cfg_we_in) begin
      cmp_mem[cfg_sp_in] <= setpoint_pkg::cmp_mode_t'(cfg_cmp_in);
      upd_mem[cfg_sp_in] <= setpoint_pkg::upd_mode_t'(cfg_upd_in);
      tgt_t_mem[cfg_sp_in] <= setpoint_pkg::target_t'(cfg_tgt_true_in);
      tgt_f_mem[cfg_sp_in] <= setpoint_pkg::target_t'(cfg_tgt_false_in);
      hi_mem[cfg_sp_in] <= cfg_high_in;
      lo_mem[cfg_sp_in] <= cfg_low_in;
      vt_mem[cfg_sp_in] <= cfg_val_true_in;
      vf_mem[cfg_sp_in] <= cfg_val_false_in;
      mt_mem[cfg_sp_in] <= cfg_mask_true_in;
      mf_mem[cfg_sp_in] <= cfg_mask_false_in;
      st_mem[cfg_sp_in] <= cfg_sel_true_in;
      sf_mem[cfg_sp_in] <= cfg_sel_false_in;
    end
  end

  // ----------------------------------------
  // comparison function
  // ----------------------------------------
  // unsigned compare; limits are raw sample codes
  function automatic logic cmp_hit(input setpoint_pkg::cmp_mode_t m,
                                   input logic [15:0] x,
                                   input logic [15:0] hi,
                                   input logic [15:0] lo);
    case (m)
      setpoint_pkg::CMP_INSIDE: cmp_hit = (x < hi) && (x > lo);
      setpoint_pkg::CMP_OUTSIDE: cmp_hit = (x > hi) || (x < lo);
      setpoint_pkg::CMP_ABOVE_LOW: cmp_hit = (x > lo);
      setpoint_pkg::CMP_BELOW_HIGH: cmp_hit = (x < hi);
      setpoint_pkg::CMP_EQUAL_HIGH: cmp_hit = (x == hi);
      default: cmp_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] result; // live status bits
    logic [15:0] hyst_high; // hysteresis: last forced value was high
    logic [15:0] seen; // evaluated in this scan
    logic [7:0] port;
    logic tmr_load;
    logic [1:0] tmr_sel;
    logic [15:0] tmr_val;
  } core_reg_t;
  core_reg_t cur_ff;
  core_reg_t nxt_ff;

  // ----------------------------------------
  // evaluation decode
  // ----------------------------------------
  logic [15:0] x; // sample actually compared
  logic hit; // current condition
  logic prev; // previous status bit
  logic fire; // an update happens now
  logic use_true; // choose true (or high) value set
  logic dac_fire;
  logic [15:0] upd_val;
  logic [1:0] upd_sel;
  logic [7:0] upd_mask;
  setpoint_pkg::target_t upd_tgt;
  setpoint_pkg::cmp_mode_t m;

  // choose the sample and decide whether to update
  always_comb begin
    x = sample_in;
    if (sample_is_count_in) begin
      x = count_high_half_in ? count_in[31:16] : count_in[15:0];
    end
    m = cmp_mem[sample_sp_in];
    prev = cur_ff.result[sample_sp_in];
    hit = 1'b0;
    fire = 1'b0;
    use_true = 1'b0;
    if (m == setpoint_pkg::CMP_HYSTERESIS) begin
      // forced update regardless of update mode
      if (sample_in_hyst_hi(x)) begin
        hit = 1'b1;
        use_true = 1'b1;
        fire = 1'b1;
      end else if (x < lo_mem[sample_sp_in]) begin
        hit = 1'b0;
        use_true = 1'b0;
        fire = 1'b1;
      end else begin
        hit = cur_ff.hyst_high[sample_sp_in];
        fire = 1'b0;
      end
    end else begin
      hit = cmp_hit(m, x, hi_mem[sample_sp_in], lo_mem[sample_sp_in]);
      use_true = hit;
      if (upd_mem[sample_sp_in] == setpoint_pkg::UPD_TRUE_FALSE) begin
        fire = 1'b1;
      end else begin
        fire = hit && !prev;
      end
    end
    // one evaluation per setpoint per scan
    if (!sample_valid_in || !sample_en_in || cur_ff.seen[sample_sp_in] || arm_in) begin
      fire = 1'b0;
    end
    upd_tgt = use_true ? tgt_t_mem[sample_sp_in] : tgt_f_mem[sample_sp_in];
    upd_val = use_true ? vt_mem[sample_sp_in] : vf_mem[sample_sp_in];
    upd_sel = use_true ? st_mem[sample_sp_in] : sf_mem[sample_sp_in];
    upd_mask = use_true ? mt_mem[sample_sp_in] : mf_mem[sample_sp_in];
    dac_fire = fire && (upd_tgt == setpoint_pkg::TGT_DAC);
  end

  // hysteresis upper crossing helper
  function automatic logic sample_in_hyst_hi(input logic [15:0] v);
    sample_in_hyst_hi = (v > hi_mem[sample_sp_in]);
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // samples arrive one per cycle in scan order, so the latest
  // write to a shared output is from the most recent true setpoint
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.tmr_load = 1'b0;
    if (arm_in) begin
      nxt_ff.result = `SP_RESULT_RST;
      nxt_ff.hyst_high = 16'h0000;
      nxt_ff.seen = 16'h0000;
    end else begin
      if (scan_end_in) begin
        nxt_ff.seen = 16'h0000;
      end
      if (sample_valid_in && sample_en_in && !cur_ff.seen[sample_sp_in]) begin
        nxt_ff.seen[sample_sp_in] = 1'b1;
        nxt_ff.result[sample_sp_in] = hit;
        if (m == setpoint_pkg::CMP_HYSTERESIS && fire) begin
          nxt_ff.hyst_high[sample_sp_in] = use_true;
        end
      end
      if (fire) begin
        case (upd_tgt)
          setpoint_pkg::TGT_PORT: begin
            // masked write, only selected bits change
            nxt_ff.port = (cur_ff.port & ~upd_mask) | (upd_val[7:0] & upd_mask);
          end
          setpoint_pkg::TGT_TIMER: begin
            nxt_ff.tmr_load = 1'b1;
            nxt_ff.tmr_sel = upd_sel;
            nxt_ff.tmr_val = upd_val;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ----------------------------------------
  // analog output path
  // ----------------------------------------
  // serial load then conversion; a later load replaces a pending one
  setpoint_dac_link #(
    .SHIFT_CYC(SHIFT_CYC),
    .CONV_CYC(CONV_CYC)
  ) u_dac (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .load_in(dac_fire),
    .chan_in(upd_sel),
    .code_in(upd_val),
    .busy_out(dac_busy_out),
    .done_out(dac_load_out),
    .dac_chan_out(dac_chan_out),
    .dac_code_out(dac_code_out)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign setpoint_result_word_out = cur_ff.result;
  assign setpoint_driven_output_port_out = cur_ff.port;
  assign timer_load_out = cur_ff.tmr_load;
  assign timer_sel_out = cur_ff.tmr_sel;
  assign timer_value_out = cur_ff.tmr_val;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_arm_clears_status: assert property (@(posedge clock_in) disable iff (!rstn_in)
    arm_in |=> setpoint_result_word_out == 16'h0000)
    else $error("status not cleared on arm");
  a_port_masked_write: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (fire && upd_tgt == setpoint_pkg::TGT_PORT) |=>
    ((setpoint_driven_output_port_out & $past(upd_mask)) ==
     ($past(upd_val[7:0]) & $past(upd_mask))))
    else $error("port masked bits wrong");
  a_port_mask_keep: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (fire && upd_tgt == setpoint_pkg::TGT_PORT) |=>
    ((setpoint_driven_output_port_out & ~$past(upd_mask)) ==
     ($past(setpoint_driven_output_port_out) & ~$past(upd_mask))))
    else $error("unmasked port bits changed");
  a_true_only_edge: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (fire && m != setpoint_pkg::CMP_HYSTERESIS &&
     upd_mem[sample_sp_in] == setpoint_pkg::UPD_TRUE_ONLY) |-> (hit && !prev))
    else $error("true-only fired without rising edge");
  a_inside_strict: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (m == setpoint_pkg::CMP_INSIDE && x == hi_mem[sample_sp_in]) |-> !hit)
    else $error("inside window not strict");
  a_hyst_between: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (m == setpoint_pkg::CMP_HYSTERESIS && x <= hi_mem[sample_sp_in] &&
     x >= lo_mem[sample_sp_in]) |-> !fire)
    else $error("hysteresis fired inside window");
  a_timer_pulse: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (fire && upd_tgt == setpoint_pkg::TGT_TIMER) |=>
    (timer_load_out && timer_sel_out == $past(upd_sel) &&
     timer_value_out == $past(upd_val)))
    else $error("timer load missing");
  a_dac_latency: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (dac_fire && !dac_busy_out) |-> ##[1:400] dac_load_out)
    else $error("dac update too slow");
  // arming must never launch an update from a stale sample
  a_arm_no_update: assert property (@(posedge clock_in) disable iff (!rstn_in)
    arm_in |-> !fire)
    else $error("update fired while arming");
  // a repeat sample in the same scan is dropped
  a_scan_once: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (sample_valid_in && cur_ff.seen[sample_sp_in]) |-> !fire)
    else $error("second evaluation in one scan");
  // a taken sample lands in its own status bit one cycle later
  a_status_bit: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (sample_valid_in && sample_en_in && !arm_in && !cur_ff.seen[sample_sp_in]) |=>
    (setpoint_result_word_out[$past(sample_sp_in)] == $past(hit)))
    else $error("status bit not updated");
  // hysteresis outside the window always forces an update
  a_hyst_forced: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (sample_valid_in && sample_en_in && !arm_in && !cur_ff.seen[sample_sp_in] &&
     m == setpoint_pkg::CMP_HYSTERESIS &&
     (x > hi_mem[sample_sp_in] || x < lo_mem[sample_sp_in])) |-> fire)
    else $error("hysteresis update not forced");
  // true-and-false mode updates on every taken sample of a non-hysteresis setpoint
  a_true_false_fire: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (sample_valid_in && sample_en_in && !arm_in && !cur_ff.seen[sample_sp_in] &&
     m != setpoint_pkg::CMP_HYSTERESIS &&
     upd_mem[sample_sp_in] == setpoint_pkg::UPD_TRUE_FALSE) |-> fire)
    else $error("true and false update missing");
  // the port is left alone unless a port update fires
  a_port_untouched: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !(fire && upd_tgt == setpoint_pkg::TGT_PORT) |=> $stable(setpoint_driven_output_port_out))
    else $error("port changed without update");
  // conversion done is a single-cycle pulse
  a_dac_done_pulse: assert property (@(posedge clock_in) disable iff (!rstn_in)
    dac_load_out |=> !dac_load_out)
    else $error("dac done pulse too long");
endmodule

// *** setpoint_detect_output_update_tb.sv ***
// self-checking bench for the setpoint detect and output update block
`timescale 1ns/1ps
module setpoint_detect_output_update_tb;
  logic clk, rstn, arm, vld, en, isc, hih, se, we, cupd;
  logic [3:0] sp, csp;
  logic [15:0] smp, chi, clo, cvt, cvf, res, tval, dcode, tseen, dseen;
  logic [31:0] cnt;
  logic [2:0] ccmp;
  logic [1:0] ctt, ctf, cst, csf, tsel, dch, twhich, dwhich;
  logic [7:0] cmt, cmf, port, port_e;
  logic tld, dld, dbusy;
  logic [15:0] stat, hs [5], ls [5], x;
  int n_mismatch, checked, i, k, n;
  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
  setpoint_detect_output_update #(.SHIFT_CYC(2), .CONV_CYC(3)) setpoint_detect_output_update_inst (
    .clock_in(clk), .rstn_in(rstn), .arm_in(arm), .sample_valid_in(vld), .sample_sp_in(sp),
    .sample_en_in(en), .sample_in(smp), .sample_is_count_in(isc), .count_high_half_in(hih),
    .count_in(cnt), .scan_end_in(se), .cfg_we_in(we), .cfg_sp_in(csp), .cfg_cmp_in(ccmp),
    .cfg_upd_in(cupd), .cfg_tgt_true_in(ctt), .cfg_tgt_false_in(ctf), .cfg_high_in(chi),
    .cfg_low_in(clo), .cfg_val_true_in(cvt), .cfg_val_false_in(cvf), .cfg_mask_true_in(cmt),
    .cfg_mask_false_in(cmf), .cfg_sel_true_in(cst), .cfg_sel_false_in(csf),
    .setpoint_result_word_out(res), .setpoint_driven_output_port_out(port),
    .timer_load_out(tld), .timer_sel_out(tsel), .timer_value_out(tval), .dac_load_out(dld),
    .dac_busy_out(dbusy), .dac_chan_out(dch), .dac_code_out(dcode));
  setpoint_output_sink setpoint_output_sink_inst (
    .clock_in(clk), .rstn_in(rstn), .timer_load_in(tld), .timer_sel_in(tsel),
    .timer_value_in(tval), .dac_load_in(dld), .dac_chan_in(dch), .dac_code_in(dcode),
    .timer_seen_out(tseen), .timer_which_out(twhich), .dac_seen_out(dseen),
    .dac_which_out(dwhich));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // expected comparison outcome, limits treated as unsigned
  function automatic logic hit(input logic [2:0] m, input logic [15:0] v, hi, lo);
    case (m)
      setpoint_pkg::CMP_INSIDE: hit = (v < hi) && (v > lo);
      setpoint_pkg::CMP_OUTSIDE: hit = (v > hi) || (v < lo);
      setpoint_pkg::CMP_ABOVE_LOW: hit = v > lo;
      setpoint_pkg::CMP_BELOW_HIGH: hit = v < hi;
      default: hit = v == hi;
    endcase
  endfunction
  task automatic chk(input logic [15:0] seen, exp, input string msg);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  task automatic cfg(input logic [3:0] s, input logic [2:0] m, input logic u,
      input logic [1:0] tt, tf, input logic [15:0] hi, lo, vt, vf,
      input logic [7:0] mt, mf, input logic [1:0] st, sf);
    @(posedge clk);
    we <= 1'b1; csp <= s; ccmp <= m; cupd <= u; ctt <= tt; ctf <= tf; chi <= hi;
    clo <= lo; cvt <= vt; cvf <= vf; cmt <= mt; cmf <= mf; cst <= st; csf <= sf;
    @(posedge clk);
    we <= 1'b0;
  endtask
  // one evaluation; ns opens a new scan first, results land on the taking edge
  task automatic samp(input logic [3:0] s, input logic [15:0] v, input logic ns);
    @(posedge clk);
    se <= ns;
    @(posedge clk);
    se <= 1'b0; vld <= 1'b1; sp <= s; smp <= v;
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rstn, arm, vld, isc, hih, se, we, cupd} = '0;
    en = 1'b1; sp = 4'h0; csp = 4'h0; smp = 16'h0000; cnt = 32'h0; ccmp = 3'h0;
    {ctt, ctf, cst, csf} = '0; {chi, clo, cvt, cvf} = '0; {cmt, cmf} = '0;
    stat = 16'h0000; port_e = 8'h00;
    n_mismatch = 0; checked = 0;
    n = $urandom(32'hb3043338);
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    chk(res, 16'h0000, "reset status");
    // five kinds, true and false values, full mask, random and boundary samples
    for (i = 0; i < 5; i++) begin
      hs[i] = 16'($urandom); ls[i] = 16'($urandom);
      cfg(4'(i), 3'(i), 1'b1, 2'h1, 2'h1, hs[i], ls[i], 16'(i + 16), 16'(i + 32),
          8'hff, 8'hff, 2'h0, 2'h0);
    end
    for (i = 0; i < 60; i++) begin
      k = $urandom % 5;
      n = $urandom % 5;
      x = (n == 0) ? hs[k] : (n == 1) ? ls[k] : (n == 2) ? ls[k] + 16'h0001 :
          (n == 3) ? hs[k] - 16'h0001 : 16'($urandom);
      samp(4'(k), x, 1'b1);
      stat[k] = hit(3'(k), x, hs[k], ls[k]);
      port_e = stat[k] ? 8'(k + 16) : 8'(k + 32);
      chk(res, stat, "status word");
      chk({8'h00, port}, {8'h00, port_e}, "port true/false");
    end
    // hysteresis: low, between, high, at the low limit, below low
    cfg(4'h5, 3'h5, 1'b0, 2'h1, 2'h1, 16'd1000, 16'd100, 16'h00aa, 16'h0055, 8'hff, 8'hff,
        2'h0, 2'h0);
    samp(4'h5, 16'd50, 1'b1);
    chk({8'h00, port}, 16'h0055, "hyst low");
    samp(4'h5, 16'd500, 1'b1);
    chk({8'h00, port}, 16'h0055, "hyst hold");
    samp(4'h5, 16'd2000, 1'b1);
    stat[5] = 1'b1;
    chk({8'h00, port}, 16'h00aa, "hyst high");
    chk(res, stat, "hyst status");
    samp(4'h5, 16'd100, 1'b1);
    chk({8'h00, port}, 16'h00aa, "hyst at low limit");
    samp(4'h5, 16'd99, 1'b1);
    stat[5] = 1'b0;
    chk({8'h00, port}, 16'h0055, "hyst back low");
    // true-only, masked low nibble, writes on rising detect only
    cfg(4'h6, 3'h2, 1'b0, 2'h1, 2'h1, 16'h0000, 16'd100, 16'h003c, 16'h00ff, 8'h0f, 8'hff,
        2'h0, 2'h0);
    samp(4'h6, 16'd50, 1'b1);
    chk({8'h00, port}, 16'h0055, "true-only false");
    samp(4'h6, 16'd200, 1'b1);
    chk({8'h00, port}, 16'h005c, "true-only masked");
    samp(4'h5, 16'd2000, 1'b1);
    samp(4'h6, 16'd300, 1'b1);
    chk({8'h00, port}, 16'h00aa, "true-only no retrigger");
    samp(4'h6, 16'd50, 1'b1);
    samp(4'h6, 16'd200, 1'b1);
    chk({8'h00, port}, 16'h00ac, "most recent wins");
    // timer targets, second sample in one scan refused
    cfg(4'h7, 3'h3, 1'b1, 2'h3, 2'h3, 16'd500, 16'h0000, 16'h1234, 16'h4321, 8'h00, 8'h00,
        2'h2, 2'h1);
    samp(4'h7, 16'd10, 1'b1);
    samp(4'h7, 16'd600, 1'b0);
    @(posedge clk);
    #1;
    chk(tseen, 16'h1234, "timer true");
    chk({14'h0000, twhich}, 16'h0002, "timer select true");
    chk(res[7], 1'b1, "second sample ignored");
    samp(4'h7, 16'd600, 1'b1);
    @(posedge clk);
    #1;
    chk(tseen, 16'h4321, "timer false");
    chk({14'h0000, twhich}, 16'h0001, "timer select false");
    // a disabled channel is never evaluated
    en <= 1'b0;
    samp(4'h7, 16'd10, 1'b1);
    en <= 1'b1;
    @(posedge clk);
    #1;
    chk(res[7], 1'b0, "disabled setpoint ignored");
    chk(tseen, 16'h4321, "disabled setpoint no timer");
    // analog output: shift plus convert cycles, counted from the taking edge
    cfg(4'h8, 3'h4, 1'b1, 2'h2, 2'h0, 16'h0077, 16'h0000, 16'hbeef, 16'h0000, 8'h00, 8'h00,
        2'h3, 2'h0);
    samp(4'h8, 16'h0077, 1'b1);
    chk({15'h0000, dbusy}, 16'h0001, "dac busy");
    n = 0;
    while (dld !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(n), 16'd5, "dac latency");
    @(posedge clk);
    #1;
    chk({14'h0000, dwhich}, 16'h0003, "dac channel");
    chk(dseen, 16'hbeef, "dac code");
    // counter halves
    cfg(4'h9, 3'h4, 1'b1, 2'h0, 2'h0, 16'habcd, 16'h0000, 16'h0000, 16'h0000, 8'h00, 8'h00,
        2'h0, 2'h0);
    isc <= 1'b1; hih <= 1'b1; cnt <= 32'habcd_0000;
    samp(4'h9, 16'h0000, 1'b1);
    chk(res[9], 1'b1, "count high half");
    hih <= 1'b0;
    samp(4'h9, 16'habcd, 1'b1);
    chk(res[9], 1'b0, "count low half");
    isc <= 1'b0;
    // arming clears every status bit
    @(posedge clk);
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    #1;
    chk(res, 16'h0000, "arm clears");
    complete_run();
  end
endmodule

// *** setpoint_output_sink.sv ***
// far-side model: timer and analog output channels that latch on load
`timescale 1ns/1ps
module setpoint_output_sink (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic timer_load_in,
  input wire logic [1:0] timer_sel_in,
  input wire logic [15:0] timer_value_in,
  input wire logic dac_load_in,
  input wire logic [1:0] dac_chan_in,
  input wire logic [15:0] dac_code_in,
  output logic [15:0] timer_seen_out,
  output logic [1:0] timer_which_out,
  output logic [15:0] dac_seen_out,
  output logic [1:0] dac_which_out
);
  // ----------------------------------------
  // latch on load pulses only
  // ----------------------------------------
  // no streaming or pattern output here, so no pacer delay is ever added
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timer_seen_out <= 16'h0000;
      timer_which_out <= 2'h0;
      dac_seen_out <= 16'h0000;
      dac_which_out <= 2'h0;
    end else begin
      if (timer_load_in) begin
        timer_seen_out <= timer_value_in;
        timer_which_out <= timer_sel_in;
      end
      if (dac_load_in) begin
        dac_seen_out <= dac_code_in;
        dac_which_out <= dac_chan_in;
      end
    end
  end
endmodule

// *** setpoint_pkg.sv ***
// types for the setpoint detect and output update block
package setpoint_pkg;
  // comparison selector
  typedef enum logic [2:0] {
    CMP_INSIDE = 3'b000,
    CMP_OUTSIDE = 3'b001,
    CMP_ABOVE_LOW = 3'b010,
    CMP_BELOW_HIGH = 3'b011,
    CMP_EQUAL_HIGH = 3'b100,
    CMP_HYSTERESIS = 3'b101
  } cmp_mode_t;
  // update target
  typedef enum logic [1:0] {
    TGT_NONE = 2'b00,
    TGT_PORT = 2'b01,
    TGT_DAC = 2'b10,
    TGT_TIMER = 2'b11
  } target_t;
  // update mode
  typedef enum logic {
    UPD_TRUE_ONLY = 1'b0,
    UPD_TRUE_FALSE = 1'b1
  } upd_mode_t;
  // dac shifter states
  typedef enum logic [1:0] {
    DAC_IDLE = 2'b00,
    DAC_SHIFT = 2'b01,
    DAC_CONV = 2'b10
  } dac_state_t;
endpackage
